// ### core/overrange_clock_out_select.v
// Top of the over-range status and auxiliary clock pin multiplexer.
// Assumes pin inputs are asynchronous; sample and setting inputs come from core_clk logic.
// How it works
// - Each status output goes high when its channel input exceeds the threshold.
// - Each over-range pulse stays high at least the programmed minimum length.
// - Channel C and D detection exists only in the four-channel variant.
// - Channel B output is used in four and two channel variants only.
// - Clocks on C and D pins need PLL enable high plus configuration.
// - With configuration zero and override off, C and D carry over-range flags.
// - Channel C clock field: 1 copy, 2 divide by two, 3 divide by four.
// - Channel C clock runs only once selected, with PLL enabled and not powered down.
// - Channel D gives an undivided copy when either configuration bit is set.
// - Divided channel D clocks come only from the software override.
// - Channel D clocks only while channel C is clocking.
// - Power-down stops the reference output and both auxiliary clocks.
// - PLL enable high runs the PLL; low disables and bypasses it.
`timescale 1ns/1ns
`default_nettype none
`include "overrange_clock_out_select_regs.vh"
module overrange_clock_out_select #(
  parameter DW = 12,
  parameter LW = 8,
  parameter [1:0] VARIANT = `VARIANT_QUAD
) (
  input wire core_clk,
  input wire nrst,
  input wire pllEnablePin,
  input wire power_down_pin,
  input wire [1:0] aux_clock_config,
  input wire overrideEnable,
  input wire [1:0] overrideSelC,
  input wire [1:0] overrideSelD,
  input wire refTick,
  input wire [DW-1:0] sampleMagA,
  input wire [DW-1:0] sampleMagB,
  input wire [DW-1:0] sampleMagC,
  input wire [DW-1:0] sampleMagD,
  input wire [DW-1:0] overrange_threshold,
  input wire [LW-1:0] overrange_min_pulse_len,
  output reg overrange_out_ch_a,
  output reg overrange_out_ch_b,
  output reg overrange_or_clk_out_ch_c,
  output reg overrange_or_clk_out_ch_d,
  output reg pll_reference_clock_out,
  output reg pllRunning,
  output reg pllBypass
);
  reg rst1_ff;
  reg rstN_ff;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst1_ff <= 1'b0;
      rstN_ff <= 1'b0;
    end else begin
      rst1_ff <= 1'b1;
      rstN_ff <= rst1_ff;
    end
  end

  // Pins are asynchronous, so each passes two flops before use.
  reg [3:0] pinSync1_ff;
  reg [3:0] pinSync2_ff;
  always @(posedge core_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      pinSync1_ff <= 4'h0;
      pinSync2_ff <= 4'h0;
    end else begin
      pinSync1_ff <= {pllEnablePin, power_down_pin, aux_clock_config};
      pinSync2_ff <= pinSync1_ff;
    end
  end
  wire pllEn = pinSync2_ff[3];
  wire pwrDown = pinSync2_ff[2];
  wire [1:0] cfgPins = pinSync2_ff[1:0];

  wire [3:0] chanEnable;
  assign chanEnable[0] = 1'b1;
  assign chanEnable[1] = (VARIANT != `VARIANT_SINGLE);
  assign chanEnable[2] = (VARIANT == `VARIANT_QUAD);
  assign chanEnable[3] = (VARIANT == `VARIANT_QUAD);
  wire [4*DW-1:0] samples = {sampleMagD, sampleMagC, sampleMagB, sampleMagA};
  wire [3:0] flags;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      overrange_detector #(.DW(DW), .LW(LW)) det (
        .clk(core_clk),
        .rstN(rstN_ff),
        .enable(chanEnable[g]),
        .sampleMag(samples[g*DW +: DW]),
        .threshold(overrange_threshold),
        .minPulseLen(overrange_min_pulse_len),
        .flag_ff(flags[g])
      );
    end
  endgenerate

  wire clocksAllowed = pllEn && !pwrDown;
  wire refClk;
  wire div2;
  wire div4;
  ref_clock_divider divider (
    .clk(core_clk),
    .rstN(rstN_ff),
    .run(clocksAllowed),
    .refTick(refTick),
    .refClk_ff(refClk),
    .div2_ff(div2),
    .div4_ff(div4)
  );

  // Pins give only the undivided copy on D; divided D needs the override.
  wire [1:0] selC = overrideEnable ? overrideSelC : cfgPins;
  wire [1:0] selDraw = overrideEnable ? overrideSelD :
    ((cfgPins != `CLKSEL_OFF) ? `CLKSEL_COPY : `CLKSEL_OFF);
  wire clkOnC = clocksAllowed && (selC != `CLKSEL_OFF);
  wire [1:0] selD = clkOnC ? selDraw : `CLKSEL_OFF;
  wire clkOnD = clocksAllowed && (selD != `CLKSEL_OFF);

  function pickClk;
    input [1:0] sel;
    input r;
    input d2;
    input d4;
    begin
      if (sel == `CLKSEL_COPY) begin
        pickClk = r;
      end else if (sel == `CLKSEL_DIV2) begin
        pickClk = d2;
      end else if (sel == `CLKSEL_DIV4) begin
        pickClk = d4;
      end else begin
        pickClk = 1'b0;
      end
    end
  endfunction

  always @(posedge core_clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      overrange_out_ch_a <= 1'b0;
      overrange_out_ch_b <= 1'b0;
      overrange_or_clk_out_ch_c <= 1'b0;
      overrange_or_clk_out_ch_d <= 1'b0;
      pll_reference_clock_out <= 1'b0;
      pllRunning <= 1'b0;
      pllBypass <= 1'b1;
    end else begin
      overrange_out_ch_a <= flags[0];
      overrange_out_ch_b <= flags[1];
      overrange_or_clk_out_ch_c <= clkOnC ? pickClk(selC, refClk, div2, div4) :
        flags[2];
      overrange_or_clk_out_ch_d <= clkOnD ? pickClk(selD, refClk, div2, div4) :
        flags[3];
      pll_reference_clock_out <= clocksAllowed ? refClk : 1'b0;
      pllRunning <= pllEn;
      pllBypass <= !pllEn;
    end
  end
endmodule
`default_nettype wire

// ### core/overrange_clock_out_select_regs.vh
// Constants for the over-range and auxiliary clock pin multiplexer.
// Assumes inclusion by bare name from the core design files.
`ifndef OVERRANGE_CLOCK_OUT_SELECT_REGS_VH
`define OVERRANGE_CLOCK_OUT_SELECT_REGS_VH
`define CLKSEL_OFF 2'h0
`define CLKSEL_COPY 2'h1
`define CLKSEL_DIV2 2'h2
`define CLKSEL_DIV4 2'h3
`define VARIANT_QUAD 2'h0
`define VARIANT_DUAL 2'h1
`define VARIANT_SINGLE 2'h2
`define THRESHOLD_RESET 12'hFFF
`define PULSE_LEN_RESET 8'h01
`endif

// ### core/overrange_detector.v
// One channel over-range detector with minimum pulse stretch.
// Assumes samples and settings come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module overrange_detector #(
  parameter DW = 12,
  parameter LW = 8
) (
  input wire clk,
  input wire rstN,
  input wire enable,
  input wire [DW-1:0] sampleMag,
  input wire [DW-1:0] threshold,
  input wire [LW-1:0] minPulseLen,
  output reg flag_ff
);
  reg [LW-1:0] holdCnt_ff;
  reg [LW-1:0] nxt_holdCnt;
  reg nxt_flag;
  wire above = enable && (sampleMag > threshold);
  always @* begin
    nxt_holdCnt = holdCnt_ff;
    nxt_flag = flag_ff;
    if (above) begin
      nxt_flag = 1'b1;
      nxt_holdCnt = minPulseLen;
    end else if (holdCnt_ff > 1) begin
      nxt_holdCnt = holdCnt_ff - 1'b1;
    end else begin
      nxt_holdCnt = {LW{1'b0}};
      nxt_flag = 1'b0;
    end
    if (!enable) begin
      nxt_flag = 1'b0;
      nxt_holdCnt = {LW{1'b0}};
    end
  end
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flag_ff <= 1'b0;
      holdCnt_ff <= {LW{1'b0}};
    end else begin
      flag_ff <= nxt_flag;
      holdCnt_ff <= nxt_holdCnt;
    end
  end
endmodule
`default_nettype wire

// ### core/ref_clock_divider.v
// Reference clock divider giving divide-by-2 and divide-by-4 levels.
// Assumes an enable pulse per reference half period from the same clock.
`timescale 1ns/1ns
`default_nettype none
module ref_clock_divider (
  input wire clk,
  input wire rstN,
  input wire run,
  input wire refTick,
  output reg refClk_ff,
  output reg div2_ff,
  output reg div4_ff
);
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      refClk_ff <= 1'b0;
      div2_ff <= 1'b0;
      div4_ff <= 1'b0;
    end else if (!run) begin
      refClk_ff <= 1'b0;
      div2_ff <= 1'b0;
      div4_ff <= 1'b0;
    end else if (refTick) begin
      refClk_ff <= ~refClk_ff;
      if (refClk_ff) begin
        div2_ff <= ~div2_ff;
        if (div2_ff) begin
          div4_ff <= ~div4_ff;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/overrange_checker.sv
// Port-level checks on the over-range and auxiliary clock pin multiplexer.
// Assumes threshold and pulse length stay put over each comparison.
`timescale 1ns/1ns
`default_nettype none
module overrange_checker #(parameter DW = 12) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pllEnablePin,
  input wire logic power_down_pin,
  input wire logic [1:0] aux_clock_config,
  input wire logic overrideEnable,
  input wire logic [DW-1:0] sampleMagA,
  input wire logic [DW-1:0] sampleMagB,
  input wire logic [DW-1:0] sampleMagC,
  input wire logic [DW-1:0] sampleMagD,
  input wire logic [DW-1:0] overrange_threshold,
  input wire logic overrange_out_ch_a,
  input wire logic overrange_out_ch_b,
  input wire logic overrange_or_clk_out_ch_c,
  input wire logic overrange_or_clk_out_ch_d,
  input wire logic pll_reference_clock_out,
  input wire logic pllRunning,
  input wire logic pllBypass
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic overA = sampleMagA > overrange_threshold;
  a_bypass_pair: assert property (pllRunning != pllBypass)
    else $error("run and bypass agree");
  a_pll_follow: assert property (pllEnablePin [*8] |-> pllRunning)
    else $error("pll not running");
  a_pd_ref: assert property (power_down_pin [*6] |-> !pll_reference_clock_out)
    else $error("ref out in power down");
  a_nopll_ref: assert property (!pllEnablePin [*6] |-> !pll_reference_clock_out)
    else $error("ref out without pll");
  a_flag_rise: assert property (overA |-> ##2 overrange_out_ch_a)
    else $error("flag a late");
  a_pulse_stretch: assert property ($rose(overrange_out_ch_a) |=> overrange_out_ch_a)
    else $error("flag a too short");
  a_flag_fall: assert property (!overA [*8] |-> !overrange_out_ch_a)
    else $error("flag a stuck");
  a_c_flag_mode: assert property ((aux_clock_config == 2'h0 && !overrideEnable
    && sampleMagC > overrange_threshold) [*6] |-> overrange_or_clk_out_ch_c)
    else $error("flag c missing");
  a_flag_b_rise: assert property (sampleMagB > overrange_threshold |-> ##2 overrange_out_ch_b)
    else $error("flag b late");
  a_d_flag_mode: assert property ((aux_clock_config == 2'h0 && !overrideEnable
    && sampleMagD > overrange_threshold) [*6] |-> overrange_or_clk_out_ch_d)
    else $error("flag d missing");
endmodule
bind overrange_clock_out_select overrange_checker #(.DW(DW)) chk (.core_clk, .nrst,
  .pllEnablePin, .power_down_pin, .aux_clock_config, .overrideEnable, .sampleMagA,
  .sampleMagB, .sampleMagC, .sampleMagD, .overrange_threshold, .overrange_out_ch_a,
  .overrange_out_ch_b, .overrange_or_clk_out_ch_c, .overrange_or_clk_out_ch_d,
  .pll_reference_clock_out, .pllRunning, .pllBypass);
`default_nettype wire

// ### verif/board_clock_receiver.sv
// Board receiver model that counts rising edges on the clock-capable pins.
// Assumes the pins are registered on core_clk, so every level is sampled.
`timescale 1ns/1ns
`default_nettype none
module board_clock_receiver (
  input wire logic core_clk,
  input wire logic clr,
  input wire logic refIn,
  input wire logic cIn,
  input wire logic dIn,
  output logic [7:0] cntR,
  output logic [7:0] cntC,
  output logic [7:0] cntD
);
  logic [2:0] last;
  // A lone auxiliary clock is taken from pin C; pin D is only a second one.
  always @(posedge core_clk) begin
    last <= {refIn, cIn, dIn};
    cntR <= clr ? 8'h00 : cntR + {7'h00, refIn & !last[2]};
    cntC <= clr ? 8'h00 : cntC + {7'h00, cIn & !last[1]};
    cntD <= clr ? 8'h00 : cntD + {7'h00, dIn & !last[0]};
  end
endmodule
`default_nettype wire

// ### verif/overrange_clock_out_select_tb.sv
// Testbench for the pin multiplexer: random samples, then a table of clock modes.
// Assumes the design header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin nMismatch++; \
  $display("ERROR %0t edge count off", $time); end end
module overrange_clock_out_select_tb;
  logic core_clk = 0, nrst = 0, pllEnablePin = 0, power_down_pin = 0, refTick = 0;
  logic overrideEnable = 0, clr = 0, on, cOn;
  logic [1:0] aux_clock_config = 0, overrideSelC = 0, overrideSelD = 0;
  logic [11:0] sampleMagA, sampleMagB, sampleMagC, sampleMagD;
  logic [11:0] overrange_threshold = 12'hFFF;
  logic [7:0] overrange_min_pulse_len = 8'h03, obs, cntR, cntC, cntD;
  logic a, b, c, d, r, run, byp;
  logic [31:0] seed = 32'h288292FB;
  // Row bits: PLL enable, power-down, config pins, override, override C, override D.
  logic [8:0] rows [13] = '{9'h140, 9'h180, 9'h1C0, 9'h106, 9'h11F, 9'h1C1, 9'h040,
    9'h120, 9'h100, 9'h160, 9'h116, 9'h112, 9'h11A};
  int nMismatch = 0, numChecks = 0, e;
  int q[$];
  event got;
  always #25 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  assign {sampleMagA, sampleMagB} = {seed[11:0] & seed[23:12], seed[19:8] & seed[31:20]};
  assign {sampleMagC, sampleMagD} = {seed[15:4] & seed[27:16], seed[11:0] & seed[31:20]};
  always @(negedge core_clk) begin
    refTick <= ~refTick;
    seed <= lfsr(seed);
  end
  overrange_clock_out_select dut (.core_clk, .nrst, .pllEnablePin, .power_down_pin,
    .aux_clock_config, .overrideEnable, .overrideSelC, .overrideSelD, .refTick,
    .sampleMagA, .sampleMagB, .sampleMagC, .sampleMagD, .overrange_threshold,
    .overrange_min_pulse_len, .overrange_out_ch_a(a), .overrange_out_ch_b(b),
    .overrange_or_clk_out_ch_c(c), .overrange_or_clk_out_ch_d(d),
    .pll_reference_clock_out(r), .pllRunning(run), .pllBypass(byp));
  board_clock_receiver rx (.core_clk, .clr, .refIn(r), .cIn(c), .dIn(d), .cntR, .cntC,
    .cntD);
  task automatic note(input int x, input logic [7:0] o);
    q.push_back(x);
    obs = o;
    ->got;
    #1;
  endtask
  always @(got) begin
    e = q.pop_front();
    `CHK(obs + 1 >= e && obs <= e + 1, 1'b1)
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    nMismatch++;
    complete_run;
  end
  initial begin
    repeat (4) @(negedge core_clk);
    nrst = 1;
    repeat (10) @(negedge core_clk);
    overrange_threshold = 12'h800;
    repeat (300) @(negedge core_clk);
    overrange_threshold = 12'h100;
    repeat (300) @(negedge core_clk);
    overrange_threshold = 12'hFFF;
    for (int i = 0; i < 13; i++) begin
      {pllEnablePin, power_down_pin, aux_clock_config, overrideEnable, overrideSelC,
        overrideSelD} = rows[i];
      on = pllEnablePin && !power_down_pin;
      cOn = on && (overrideEnable ? overrideSelC != 0 : aux_clock_config != 0);
      repeat (20) @(negedge core_clk);
      clr = 1;
      @(negedge core_clk) clr = 0;
      repeat (128) @(negedge core_clk);
      note(on ? 32 : 0, cntR);
      note(cOn ? 64 >> (overrideEnable ? overrideSelC : aux_clock_config) : 0, cntC);
      note(!cOn ? 0 : !overrideEnable ? 32 : 64 >> overrideSelD, cntD);
    end
    complete_run;
  end
endmodule
`default_nettype wire
